/* inc/stop_cfg.svh */
`ifndef STOP_CFG_SVH
`define STOP_CFG_SVH

// ==========================================================
// Register addresses
`define STOP_ADDR_CFG0      8'h00
`define STOP_ADDR_CFG6      8'h06
`define STOP_ADDR_CTRL      8'h08
`define STOP_ADDR_FLAG      8'h09
`define STOP_ADDR_CLR       8'h0a
`define STOP_ADDR_IEN       8'h0b
`define STOP_ADDR_LVL       8'h0c
`define STOP_ADDR_SHORT     8'h0d

// ==========================================================
// Field positions
`define STOP_CTRL_HIZ       0
`define STOP_CTRL_SW        1
`define STOP_FLAG_SHORT_CTM 7
`define STOP_FLAG_SHORT_PWM 8
`define STOP_FLAG_SW        9
`define STOP_FLAG_OSC       10
`define STOP_FLAG_CMP       11

// ==========================================================
// Reset values
`define STOP_CFG_RST        8'h00
`define STOP_HIZ_RST        1'b1
`define STOP_IEN_RST        12'h000

// ==========================================================
// Input mode and sample count codes
`define STOP_MODE_EDGE      4'h0
`define STOP_MODE_DIV8      4'h1
`define STOP_MODE_DIV16     4'h2
`define STOP_MODE_DIV128    4'h3
`define STOP_MODE_DIV1      4'h4
`define STOP_MODE_DIV2      4'h5
`define STOP_MODE_DIV4      4'h6
`define STOP_CNT_16         4'h0
`define STOP_CNT_4          4'h1
`define STOP_CNT_8          4'h2
`define STOP_SAMPLES_16     5'h10
`define STOP_SAMPLES_4      5'h04
`define STOP_SAMPLES_8      5'h08

// ==========================================================
// Sampling prescaler
`define STOP_PRE_MAX        7'h7f

`endif

/* inc/stop_pkg.sv */
package stop_pkg;
  typedef logic [7:0]  addr_type;
  typedef logic [31:0] data_type;
  typedef logic [3:0]  code_type;
  typedef logic [6:0]  pin_vec_type;
  typedef logic [19:0] ctm_vec_type;
  typedef logic [15:0] pwm_vec_type;
  typedef logic [11:0] flag_vec_type;
  typedef logic [5:0]  tick_vec_type;
endpackage

/* rtl/stop_input_filter.sv */
`timescale 1ns/10ps
`include "stop_cfg.svh"

module stop_input_filter (
  // Clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_b,
  // Pin and configuration
  input  wire logic                   i_pin_b,
  input  wire stop_pkg::code_type     i_mode,
  input  wire stop_pkg::code_type     i_count,
  input  wire stop_pkg::tick_vec_type i_ticks,
  // Results
  output logic                        o_req,
  output logic                        o_level
);
  import stop_pkg::*;

  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic [4:0] run_r;
  logic [4:0] run_nxt;
  logic       tick;
  logic       legal;
  logic [4:0] target;
  logic       fall;
  logic       hit;

  // ==========================================================
  // Mode decode
  assign tick = (i_mode == `STOP_MODE_DIV1)   ? i_ticks[0] :
                (i_mode == `STOP_MODE_DIV2)   ? i_ticks[1] :
                (i_mode == `STOP_MODE_DIV4)   ? i_ticks[2] :
                (i_mode == `STOP_MODE_DIV8)   ? i_ticks[3] :
                (i_mode == `STOP_MODE_DIV16)  ? i_ticks[4] :
                (i_mode == `STOP_MODE_DIV128) ? i_ticks[5] : 1'b0;
  assign target = (i_count == `STOP_CNT_16) ? `STOP_SAMPLES_16 :
                  (i_count == `STOP_CNT_4)  ? `STOP_SAMPLES_4  :
                  (i_count == `STOP_CNT_8)  ? `STOP_SAMPLES_8  : 5'h00;
  // Prohibited codes never raise a sampled request; edge mode ignores the count code
  assign legal = (target != 5'h00) && (i_mode != `STOP_MODE_EDGE) && (i_mode <= `STOP_MODE_DIV4);

  // ==========================================================
  // Detection
  assign fall    = (i_mode == `STOP_MODE_EDGE) && prev_r && !sync2_r;
  assign run_nxt = !tick ? run_r :
                   sync2_r ? 5'h00 :
                   (run_r == target) ? run_r : run_r + 5'h01;
  assign hit     = legal && tick && !sync2_r && (run_r + 5'h01 == target);
  assign o_level = prev_r;

  // Pins idle high; reset to high so release never looks like an edge
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r  <= 1'b1;
      run_r   <= 5'h00;
      o_req   <= 1'b0;
    end else begin
      sync1_r <= i_pin_b;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
      run_r   <= legal ? run_nxt : 5'h00;
      o_req   <= fall || hit;
    end
  end
endmodule

/* rtl/output_stop_unit.sv */
// Summary of operation
// - Stopped pins go high impedance or back to port control, per control bit.
// - Controls 20 complementary timer pins and 16 general PWM timer pins.
// - A qualified event on any of seven stop inputs raises a stop request.
// - Both outputs of a monitored pair active in one cycle means short circuit.
// - Monitored pairs: 3B/3D, 4A/4C, 4B/4D, 6B/6D, 7A/7C, 7B/7D, PWM 0-2,4-7.
// - Writing the software stop bit raises a stop request.
// - Main oscillator stop report stops all controlled outputs.
// - Comparator detection output raises a stop request.
// - Each stop input selects falling-edge or low-level detection on its own.
// - Level sampling clock is the clock divided by 1, 2, 4, 8, 16 or 128.
// - Level detection needs 4, 8 or 16 agreeing samples.
// - Any stop input detection stops every controlled pin.
// - Mode codes: 0 edge, 1/2/3 divide 8/16/128, 4/5/6 divide 1/2/4.
// - Count codes: 0 gives 16, 1 gives 4, 2 gives 8 samples.
// - A sampled request needs that many consecutive low samples.
// - Sampling and comparison results can raise the interrupt.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "stop_cfg.svh"

module output_stop_unit (
  // Clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_b,
  // Register port
  input  wire stop_pkg::addr_type     i_addr,
  input  wire stop_pkg::data_type     i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output stop_pkg::data_type          o_rdata,
  // Stop sources
  input  wire stop_pkg::pin_vec_type  i_stop_in_b,
  input  wire logic                   i_osc_stopped,
  input  wire logic                   i_cmp_detect,
  // Complementary timer pins, from timer
  input  wire stop_pkg::ctm_vec_type  i_ctm_level,
  input  wire stop_pkg::ctm_vec_type  i_ctm_oe_b,
  // Complementary timer pins, to pad
  output stop_pkg::ctm_vec_type       o_ctm_pin,
  output stop_pkg::ctm_vec_type       o_ctm_pin_oe_b,
  output stop_pkg::ctm_vec_type       o_ctm_port_sel,
  // General PWM timer pins, from timer
  input  wire stop_pkg::pwm_vec_type  i_pwm_level,
  input  wire stop_pkg::pwm_vec_type  i_pwm_oe_b,
  // General PWM timer pins, to pad
  output stop_pkg::pwm_vec_type       o_pwm_pin,
  output stop_pkg::pwm_vec_type       o_pwm_pin_oe_b,
  output stop_pkg::pwm_vec_type       o_pwm_port_sel,
  // Status
  output logic                        o_stopped,
  output logic                        o_irq
);
  import stop_pkg::*;

  // ==========================================================
  // Declarations
  logic [7:0]   cfg_r [0:6];
  logic         hiz_r;
  flag_vec_type flag_r;
  flag_vec_type flag_nxt;
  flag_vec_type ien_r;
  flag_vec_type set_vec;
  flag_vec_type clr_vec;
  logic [6:0]   pre_r;
  tick_vec_type ticks;
  pin_vec_type  in_req;
  pin_vec_type  in_level;
  logic [5:0]   ctm_short;
  logic [6:0]   pwm_short;
  logic         any_ctm_short;
  logic         any_pwm_short;
  logic         stop_nxt;
  logic         wr_cfg;
  logic         wr_ctrl;
  logic         wr_clr;
  logic         wr_ien;
  logic         sw_stop;
  logic [2:0]   cfg_idx;
  data_type     rd_mux;
  data_type     rd_cfg;

  // ==========================================================
  // Register write decode
  assign wr_cfg  = i_wr && (i_addr <= `STOP_ADDR_CFG6);
  assign wr_ctrl = i_wr && (i_addr == `STOP_ADDR_CTRL);
  assign wr_clr  = i_wr && (i_addr == `STOP_ADDR_CLR);
  assign wr_ien  = i_wr && (i_addr == `STOP_ADDR_IEN);
  assign cfg_idx = i_addr[2:0];
  // The software stop bit is an action, not stored state
  assign sw_stop = wr_ctrl && i_wdata[`STOP_CTRL_SW];
  assign clr_vec = wr_clr ? i_wdata[11:0] : 12'h000;

  // ==========================================================
  // Sampling prescaler shared by all stop inputs
  assign ticks[0] = 1'b1;
  assign ticks[1] = (pre_r[0] == 1'b1);
  assign ticks[2] = (pre_r[1:0] == 2'h3);
  assign ticks[3] = (pre_r[2:0] == 3'h7);
  assign ticks[4] = (pre_r[3:0] == 4'hf);
  assign ticks[5] = (pre_r == `STOP_PRE_MAX);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pre_r <= 7'h00;
    end else begin
      pre_r <= pre_r + 7'h01;
    end
  end

  // ==========================================================
  // Stop request inputs
  generate
    for (genvar n = 0; n < 7; n++) begin : g_in
      stop_input_filter u_filter (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_pin_b (i_stop_in_b[n]),
        .i_mode  (cfg_r[n][3:0]),
        .i_count (cfg_r[n][7:4]),
        .i_ticks (ticks),
        .o_req   (in_req[n]),
        .o_level (in_level[n])
      );
    end
  endgenerate

  // ==========================================================
  // Short circuit monitor, active level is high
  // Vector order: ch0 A-D, ch3 B D, ch4 A-D, ch6 B D, ch7 A-D, ch9 A-D
  assign ctm_short[0] = i_ctm_level[4]  && i_ctm_level[5];
  assign ctm_short[1] = i_ctm_level[6]  && i_ctm_level[8];
  assign ctm_short[2] = i_ctm_level[7]  && i_ctm_level[9];
  assign ctm_short[3] = i_ctm_level[10] && i_ctm_level[11];
  assign ctm_short[4] = i_ctm_level[12] && i_ctm_level[14];
  assign ctm_short[5] = i_ctm_level[13] && i_ctm_level[15];
  // PWM vector holds A at 2n and B at 2n+1; channel 3 is not watched
  assign pwm_short[0] = i_pwm_level[0]  && i_pwm_level[1];
  assign pwm_short[1] = i_pwm_level[2]  && i_pwm_level[3];
  assign pwm_short[2] = i_pwm_level[4]  && i_pwm_level[5];
  assign pwm_short[3] = i_pwm_level[8]  && i_pwm_level[9];
  assign pwm_short[4] = i_pwm_level[10] && i_pwm_level[11];
  assign pwm_short[5] = i_pwm_level[12] && i_pwm_level[13];
  assign pwm_short[6] = i_pwm_level[14] && i_pwm_level[15];
  assign any_ctm_short = |ctm_short;
  assign any_pwm_short = |pwm_short;

  // ==========================================================
  // Source flags
  assign set_vec[6:0]                 = in_req;
  assign set_vec[`STOP_FLAG_SHORT_CTM] = any_ctm_short;
  assign set_vec[`STOP_FLAG_SHORT_PWM] = any_pwm_short;
  assign set_vec[`STOP_FLAG_SW]        = sw_stop;
  assign set_vec[`STOP_FLAG_OSC]       = i_osc_stopped;
  assign set_vec[`STOP_FLAG_CMP]       = i_cmp_detect;
  // A set in the clearing cycle wins, so no event is lost
  assign flag_nxt = (flag_r & ~clr_vec) | set_vec;
  assign stop_nxt = |flag_nxt;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      flag_r <= 12'h000;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      for (int k = 0; k < 7; k++) begin
        cfg_r[k] <= `STOP_CFG_RST;
      end
    end else if (wr_cfg) begin
      cfg_r[cfg_idx] <= i_wdata[7:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      hiz_r <= `STOP_HIZ_RST;
      ien_r <= `STOP_IEN_RST;
    end else begin
      if (wr_ctrl) begin
        hiz_r <= i_wdata[`STOP_CTRL_HIZ];
      end
      if (wr_ien) begin
        ien_r <= i_wdata[11:0];
      end
    end
  end

  // ==========================================================
  // Pin control
  // While stopped the timer drive is cut; with hiz_r clear, port select hands the pad to GPIO
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_ctm_pin      <= 20'h00000;
      o_ctm_pin_oe_b <= 20'hfffff;
      o_ctm_port_sel <= 20'h00000;
      o_pwm_pin      <= 16'h0000;
      o_pwm_pin_oe_b <= 16'hffff;
      o_pwm_port_sel <= 16'h0000;
      o_stopped      <= 1'b0;
    end else if (stop_nxt) begin
      o_ctm_pin      <= 20'h00000;
      o_ctm_pin_oe_b <= 20'hfffff;
      o_ctm_port_sel <= {20{!hiz_r}};
      o_pwm_pin      <= 16'h0000;
      o_pwm_pin_oe_b <= 16'hffff;
      o_pwm_port_sel <= {16{!hiz_r}};
      o_stopped      <= 1'b1;
    end else begin
      o_ctm_pin      <= i_ctm_level;
      o_ctm_pin_oe_b <= i_ctm_oe_b;
      o_ctm_port_sel <= 20'h00000;
      o_pwm_pin      <= i_pwm_level;
      o_pwm_pin_oe_b <= i_pwm_oe_b;
      o_pwm_port_sel <= 16'h0000;
      o_stopped      <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(flag_nxt & ien_r);
    end
  end

  // ==========================================================
  // Register read
  assign rd_cfg = {24'h000000, cfg_r[cfg_idx]};
  assign rd_mux = (i_addr <= `STOP_ADDR_CFG6)    ? rd_cfg :
                  (i_addr == `STOP_ADDR_CTRL)    ? {31'h00000000, hiz_r} :
                  (i_addr == `STOP_ADDR_FLAG)    ? {20'h00000, flag_r} :
                  (i_addr == `STOP_ADDR_IEN)     ? {20'h00000, ien_r} :
                  (i_addr == `STOP_ADDR_LVL)     ? {25'h0000000, in_level} :
                  (i_addr == `STOP_ADDR_SHORT)   ? {19'h00000, pwm_short, ctm_short} :
                  32'h00000000;

  // Read data stands for one cycle only
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= 32'h00000000;
    end
  end
endmodule

/* testbench/output_stop_unit_props.sv */
`timescale 1ns/10ps
`include "stop_cfg.svh"

module output_stop_unit_props (
  // Clock, reset and register port
  input wire logic                  i_mclk,
  input wire logic                  i_rst_b,
  input wire stop_pkg::addr_type    i_addr,
  input wire stop_pkg::data_type    i_wdata,
  input wire logic                  i_wr,
  input wire logic                  i_rd,
  input wire stop_pkg::data_type    o_rdata,
  // Stop sources
  input wire logic                  i_osc_stopped,
  input wire logic                  i_cmp_detect,
  // Timer pins
  input wire stop_pkg::ctm_vec_type i_ctm_level,
  input wire stop_pkg::ctm_vec_type i_ctm_oe_b,
  input wire stop_pkg::ctm_vec_type o_ctm_pin,
  input wire stop_pkg::ctm_vec_type o_ctm_pin_oe_b,
  input wire stop_pkg::pwm_vec_type i_pwm_level,
  input wire stop_pkg::pwm_vec_type o_pwm_pin,
  input wire stop_pkg::pwm_vec_type o_pwm_pin_oe_b,
  // Status
  input wire logic                  o_stopped,
  input wire logic                  o_irq
);
  import stop_pkg::*;
  // ========================================
  // Watched pairs; PWM channel 3 is left out on purpose
  ctm_vec_type c;
  pwm_vec_type p;
  logic [12:0] short_w;
  logic        clr_w;
  assign c = i_ctm_level;
  assign p = i_pwm_level;
  assign short_w = {&p[15:14], &p[13:12], &p[11:10], &p[9:8], &p[5:4], &p[3:2], &p[1:0],
                    c[13] & c[15], c[12] & c[14], c[10] & c[11], c[7] & c[9], c[6] & c[8],
                    c[4] & c[5]};
  assign clr_w = i_wr && i_addr == `STOP_ADDR_CLR;

  // ========================================
  // Properties
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  property p_stop_oe; o_stopped |-> &o_ctm_pin_oe_b && &o_pwm_pin_oe_b; endproperty
  a_stop_oe: assert property (p_stop_oe) else $error("stopped pin still driven");
  property p_stop_pin; o_stopped |-> o_ctm_pin == '0 && o_pwm_pin == '0; endproperty
  a_stop_pin: assert property (p_stop_pin) else $error("stopped pin not low");
  property p_pass;
    !o_stopped && $past(i_rst_b) |-> o_ctm_pin == $past(i_ctm_level) &&
      o_ctm_pin_oe_b == $past(i_ctm_oe_b) && o_pwm_pin == $past(i_pwm_level);
  endproperty
  a_pass: assert property (p_pass) else $error("timer pin not passed through");
  property p_short; |short_w |=> o_stopped; endproperty
  a_short: assert property (p_short) else $error("short pair missed");
  property p_osc; i_osc_stopped |=> o_stopped; endproperty
  a_osc: assert property (p_osc) else $error("oscillator stop missed");
  property p_cmp; i_cmp_detect |=> o_stopped; endproperty
  a_cmp: assert property (p_cmp) else $error("comparator detect missed");
  property p_sw; i_wr && i_addr == `STOP_ADDR_CTRL && i_wdata[1] |=> o_stopped; endproperty
  a_sw: assert property (p_sw) else $error("software stop missed");
  property p_hold; o_stopped && !clr_w |=> o_stopped; endproperty
  a_hold: assert property (p_hold) else $error("stop released without clear");
  property p_irq; o_irq |-> o_stopped; endproperty
  a_irq: assert property (p_irq) else $error("interrupt without stop");
  property p_rdata; !$past(i_rd) |-> o_rdata == '0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its cycle");

  c_stop: cover property ($rose(o_stopped));
  c_irq: cover property ($rose(o_irq));
  c_release: cover property ($fell(o_stopped));
endmodule

bind output_stop_unit output_stop_unit_props u_props (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_osc_stopped(i_osc_stopped), .i_cmp_detect(i_cmp_detect),
  .i_ctm_level(i_ctm_level), .i_ctm_oe_b(i_ctm_oe_b), .o_ctm_pin(o_ctm_pin),
  .o_ctm_pin_oe_b(o_ctm_pin_oe_b), .i_pwm_level(i_pwm_level), .o_pwm_pin(o_pwm_pin),
  .o_pwm_pin_oe_b(o_pwm_pin_oe_b), .o_stopped(o_stopped), .o_irq(o_irq));

/* testbench/pwm_pin_model.sv */
`timescale 1ns/10ps

module pwm_pin_model (
  // Clock, reset and fault command
  input  wire logic             i_mclk,
  input  wire logic             i_rst_b,
  input  wire logic [1:0]       i_fault,
  // Timer pins towards the stop unit
  output stop_pkg::ctm_vec_type o_ctm_level,
  output stop_pkg::ctm_vec_type o_ctm_oe_b,
  output stop_pkg::pwm_vec_type o_pwm_level,
  output stop_pkg::pwm_vec_type o_pwm_oe_b
);
  import stop_pkg::*;
  logic        phase_r;
  ctm_vec_type ctm_w;
  pwm_vec_type pwm_w;

  always_ff @(posedge i_mclk) begin
    phase_r <= i_rst_b ? ~phase_r : 1'b0;
  end
  // ========================================
  // Watched pair members always oppose; a fault forces one pair both active at once
  assign ctm_w = phase_r ? 20'h534d5 : ~20'h534d5;
  assign pwm_w = phase_r ? 16'h5555 : 16'haaaa;
  assign o_ctm_level = (i_fault == 2'h1) ? (ctm_w | 20'h00030) : ctm_w;
  assign o_pwm_level = (i_fault == 2'h2) ? (pwm_w | 16'hc000) :
                       (i_fault == 2'h3) ? (pwm_w | 16'h00c0) : pwm_w;
  assign o_ctm_oe_b = 20'h80000;
  assign o_pwm_oe_b = 16'h0000;
endmodule

/* testbench/tb_pwm_output_emergency_stop.sv */
`timescale 1ns/10ps
`include "stop_cfg.svh"

module tb_pwm_output_emergency_stop;
  import stop_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_rst_b = 1'b0;
  addr_type    i_addr = 8'h00;
  data_type    i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  pin_vec_type i_stop_in_b = 7'h7f;
  logic        i_osc_stopped = 1'b0;
  logic        i_cmp_detect = 1'b0;
  logic [1:0]  fault = 2'h0;
  data_type    o_rdata;
  ctm_vec_type ctm_level, ctm_oe_b, o_ctm_pin, o_ctm_pin_oe_b, o_ctm_port_sel;
  pwm_vec_type pwm_level, pwm_oe_b, o_pwm_pin, o_pwm_pin_oe_b, o_pwm_port_sel;
  logic        o_stopped, o_irq;
  int          errors = 0;
  int          checks = 0;

  always #2.5 i_mclk = ~i_mclk;

  output_stop_unit u_dut (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_stop_in_b(i_stop_in_b), .i_osc_stopped(i_osc_stopped),
    .i_cmp_detect(i_cmp_detect), .i_ctm_level(ctm_level), .i_ctm_oe_b(ctm_oe_b),
    .o_ctm_pin(o_ctm_pin), .o_ctm_pin_oe_b(o_ctm_pin_oe_b), .o_ctm_port_sel(o_ctm_port_sel),
    .i_pwm_level(pwm_level), .i_pwm_oe_b(pwm_oe_b), .o_pwm_pin(o_pwm_pin),
    .o_pwm_pin_oe_b(o_pwm_pin_oe_b), .o_pwm_port_sel(o_pwm_port_sel), .o_stopped(o_stopped),
    .o_irq(o_irq));

  pwm_pin_model u_pins (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_fault(fault), .o_ctm_level(ctm_level),
    .o_ctm_oe_b(ctm_oe_b), .o_pwm_level(pwm_level), .o_pwm_oe_b(pwm_oe_b));

  // ========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic wr(input addr_type a, input data_type d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input addr_type a, input data_type e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask

  // ========================================
  // Scenarios
  task automatic t_regs;
    #1 chk(o_stopped, 1'b0);
    rd(`STOP_ADDR_CTRL, 32'h1);
    rd(`STOP_ADDR_FLAG, 32'h0);
    rd(`STOP_ADDR_IEN, 32'h0);
    rd(8'h07, 32'h0);
    rd(8'h3f, 32'h0);
    wr(`STOP_ADDR_CFG6, 32'h21);
    rd(`STOP_ADDR_CFG6, 32'h21);
    wr(`STOP_ADDR_CFG6, 32'h0);
    rd(`STOP_ADDR_LVL, 32'h7f);
    $display("t_regs done");
  endtask

  task automatic t_sources;
    int       bitn [5] = '{11, 10, 9, 7, 8};
    data_type m;
    for (int k = 0; k < 5; k++) begin
      m = 32'h1 << bitn[k];
      wr(`STOP_ADDR_CTRL, {31'h0, k[0]});
      wr(`STOP_ADDR_IEN, k[0] ? 32'h0 : m);
      @(posedge i_mclk);
      case (k)
        0: i_cmp_detect <= 1'b1;
        1: i_osc_stopped <= 1'b1;
        2: begin
          i_addr <= `STOP_ADDR_CTRL;
          i_wdata <= 32'h2;
          i_wr <= 1'b1;
        end
        default: fault <= k[1:0] - 2'h2;
      endcase
      @(posedge i_mclk);
      {i_cmp_detect, i_osc_stopped, i_wr} <= 3'h0;
      fault <= 2'h0;
      #1 chk(o_stopped, 1'b1);
      chk(o_ctm_pin_oe_b, 20'hfffff);
      chk(o_pwm_port_sel, k[0] ? 16'h0 : 16'hffff);
      chk(o_ctm_port_sel, k[0] ? 20'h0 : 20'hfffff);
      chk(o_irq, !k[0]);
      tick(3);
      chk(o_stopped, 1'b1);
      rd(`STOP_ADDR_FLAG, m);
      wr(`STOP_ADDR_CLR, m);
      tick(1);
      chk(o_stopped, 1'b0);
      chk(o_ctm_pin_oe_b, 20'h80000);
    end
    @(posedge i_mclk);
    fault <= 2'h3;
    tick(3);
    chk(o_stopped, 1'b0);
    @(posedge i_mclk);
    fault <= 2'h2;
    rd(`STOP_ADDR_SHORT, 32'h1000);
    chk(o_stopped, 1'b1);
    @(posedge i_mclk);
    fault <= 2'h0;
    wr(`STOP_ADDR_CLR, 32'h100);
    tick(1);
    chk(o_stopped, 1'b0);
    $display("t_sources done");
  endtask

  task automatic t_edge;
    @(posedge i_mclk);
    i_stop_in_b <= 7'h77;
    tick(3);
    chk(o_stopped, 1'b0);
    tick(1);
    chk(o_stopped, 1'b1);
    rd(`STOP_ADDR_FLAG, 32'h8);
    @(posedge i_mclk);
    i_stop_in_b <= 7'h7f;
    wr(`STOP_ADDR_CLR, 32'h8);
    tick(1);
    chk(o_stopped, 1'b0);
    $display("t_edge done");
  endtask

  task automatic t_sampling;
    data_type cfg [10] = '{32'h14, 32'h15, 32'h16, 32'h11, 32'h12, 32'h13, 32'h24, 32'h04,
                           32'h17, 32'h34};
    int       dv [10] = '{1, 2, 4, 8, 16, 128, 1, 1, 0, 0};
    int       cn [10] = '{4, 4, 4, 4, 4, 4, 8, 16, 0, 0};
    int       n;
    logic     ok;
    wr(`STOP_ADDR_IEN, 32'h1);
    wr(`STOP_ADDR_CFG0, 32'h14);
    @(posedge i_mclk);
    i_stop_in_b <= 7'h7e;
    repeat (3) @(posedge i_mclk);
    i_stop_in_b <= 7'h7f;
    tick(12);
    chk(o_stopped, 1'b0);
    for (int k = 0; k < 10; k++) begin
      wr(`STOP_ADDR_CFG0, cfg[k]);
      // Pin stays high until the new divider ticks, so a held count is cleared
      repeat (130) @(posedge i_mclk);
      i_stop_in_b <= 7'h7e;
      n = 0;
      do begin
        @(posedge i_mclk);
        #1 n++;
      end while (o_stopped !== 1'b1 && n < 600);
      ok = dv[k] ? (n >= (cn[k] - 1) * dv[k] + 3 && n <= cn[k] * dv[k] + 7) : n == 600;
      chk(ok, 1'b1);
      chk(o_irq, dv[k] != 0);
      @(posedge i_mclk);
      i_stop_in_b <= 7'h7f;
      wr(`STOP_ADDR_CLR, 32'h1);
      tick(1);
      chk(o_stopped, 1'b0);
    end
    $display("t_sampling done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    t_regs();
    t_sources();
    t_edge();
    t_sampling();
    tally_and_finish();
  end
endmodule
